/* dv/test_dpll_phase_monitor_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_dpll_phase_monitor_regs;
    import dpll_phase_monitor_pkg::*;
    localparam int SEC = 10;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] cpuAddr = 8'h00;
    logic [7:0] cpuWrData = 8'h00;
    logic cpuWrEn = 1'b0;
    logic cpuRdEn = 1'b0;
    logic [7:0] cpuRdData;
    logic signed [15:0] primaryPhase = 16'sh0000;
    logic signed [15:0] secondaryPhase = 16'sh0000;
    logic primaryPhaseValid = 1'b0;
    logic secondaryPhaseValid = 1'b0;
    logic phaseSourceDpllSelect = 1'b0;
    logic monitorEnable = 1'b0;
    logic buildOutOnAlarmEnable = 1'b0;
    logic [3:0] transientLimit = 4'h0;
    logic [15:0] phaseErrQns = 16'h0000;
    logic phaseErrValid = 1'b0;
    logic phaseTransientAlarm;
    logic phaseBuildOutPulse;
    logic lockAttempt = 1'b0;
    logic phaseAlarm;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [15:0] expAvg;
    logic [15:0] thr;

    dpll_phase_monitor_regs #(.PHASE_WIDTH(16), .AVG_SHIFT(4), .SECOND_CYCLES(SEC)) uut (
        .clk(clk), .rstn(rstn), .cpuAddr(cpuAddr), .cpuWrData(cpuWrData), .cpuWrEn(cpuWrEn),
        .cpuRdEn(cpuRdEn), .cpuRdData(cpuRdData), .primaryPhase(primaryPhase),
        .primaryPhaseValid(primaryPhaseValid), .secondaryPhase(secondaryPhase),
        .secondaryPhaseValid(secondaryPhaseValid), .phaseSourceDpllSelect(phaseSourceDpllSelect),
        .monitorEnable(monitorEnable), .buildOutOnAlarmEnable(buildOutOnAlarmEnable),
        .transientLimit(transientLimit), .phaseErrQns(phaseErrQns), .phaseErrValid(phaseErrValid),
        .phaseTransientAlarm(phaseTransientAlarm), .phaseBuildOutPulse(phaseBuildOutPulse),
        .lockAttempt(lockAttempt), .phaseAlarm(phaseAlarm));

    always #4 clk = ~clk;

    // ==========================================================
    // Reporting.
    task automatic close_out();
        if (failures == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            failures++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        if (seen !== exp)
            failures++;
    endtask : check

    // ==========================================================
    // Register port and stimulus helpers.
    task automatic do_reset();
        rstn = 1'b0;
        repeat (12) @(posedge clk);
        #1 rstn = 1'b1;
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cpuAddr = a;
        cpuWrData = d;
        cpuWrEn = 1'b1;
        @(posedge clk);
        #1 cpuWrEn = 1'b0;
        @(posedge clk);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        cpuAddr = a;
        cpuRdEn = 1'b1;
        @(posedge clk);
        #1 cpuRdEn = 1'b0;
        check(what, {8'h00, cpuRdData}, {8'h00, exp});
        @(posedge clk);
        #1;
    endtask : rd

    // Write immediately followed by a read of the same register.
    task automatic wrRd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp, input string what);
        cpuAddr = a;
        cpuWrData = d;
        cpuWrEn = 1'b1;
        @(posedge clk);
        #1 cpuWrEn = 1'b0;
        cpuRdEn = 1'b1;
        @(posedge clk);
        #1 cpuRdEn = 1'b0;
        check(what, {8'h00, cpuRdData}, {8'h00, exp});
        @(posedge clk);
        #1;
    endtask : wrRd

    // Back-to-back read of the low byte and then the high byte.
    task automatic rdPair(input logic [15:0] exp);
        cpuAddr = PHASE_LOW_OFFSET;
        cpuRdEn = 1'b1;
        @(posedge clk);
        #1 check("phase low", {8'h00, cpuRdData}, {8'h00, exp[7:0]});
        cpuAddr = PHASE_HIGH_OFFSET;
        @(posedge clk);
        #1 cpuRdEn = 1'b0;
        check("phase high", {8'h00, cpuRdData}, {8'h00, exp[15:8]});
        @(posedge clk);
        #1;
    endtask : rdPair

    task automatic pulseSamples(input int n);
        repeat (n)
        begin
            primaryPhaseValid = 1'b1;
            secondaryPhaseValid = 1'b1;
            @(posedge clk);
            #1 primaryPhaseValid = 1'b0;
            secondaryPhaseValid = 1'b0;
            @(posedge clk);
            #1;
        end
    endtask : pulseSamples

    task automatic errPulse(input logic [15:0] q);
        phaseErrQns = q;
        phaseErrValid = 1'b1;
        @(posedge clk);
        #1 phaseErrValid = 1'b0;
    endtask : errPulse

    task automatic waitAlarm(input logic want, input int lim);
        int k;
        k = 0;
        while (phaseAlarm !== want && k < lim)
        begin
            @(posedge clk);
            #1 k++;
        end
    endtask : waitAlarm

    // Running average with a 1/16 weight, as the readout is defined.
    function automatic logic [15:0] avgOf(input int s, input int n);
        int acc;
        acc = 0;
        for (int i = 0; i < n; i++)
            acc = acc + s - (acc >>> 4);
        return 16'(acc >>> 4);
    endfunction : avgOf

    // ==========================================================
    // Test sequence.
    initial
    begin
        do_reset();
        rd(PHASE_LOW_OFFSET, PHASE_LOW_RESET, "low reset");
        rd(PHASE_HIGH_OFFSET, PHASE_HIGH_RESET, "high reset");
        rd(TIMEOUT_OFFSET, TIMEOUT_RESET, "timeout reset");
        rd(8'h40, 8'h00, "unmapped");
        wr(PHASE_LOW_OFFSET, 8'hAA);
        rd(PHASE_LOW_OFFSET, 8'h00, "low read-only");
        wrRd(TIMEOUT_OFFSET, 8'hD5, 8'h15, "timeout rw");
        for (int sel = 0; sel < 2; sel++)
        begin
            do_reset();
            phaseSourceDpllSelect = sel[0];
            primaryPhase = -16'sd2048;
            secondaryPhase = 16'sd1000;
            pulseSamples(4);
            expAvg = (sel == 1) ? avgOf(1000, 4) : avgOf(-2048, 4);
            rdPair(expAvg);
            pulseSamples(1);
            rd(PHASE_HIGH_OFFSET, expAvg[15:8], "high frozen");
        end
        for (int i = 0; i < 2; i++)
        begin
            transientLimit = (i == 0) ? 4'h0 : 4'hF;
            thr = 16'((int'(transientLimit) + 7) * 625);
            buildOutOnAlarmEnable = (i == 0);
            monitorEnable = 1'b0;
            errPulse(thr + 16'h0001);
            check("alarm disabled", {15'h0, phaseTransientAlarm}, 16'h0000);
            monitorEnable = 1'b1;
            errPulse(thr);
            check("alarm at limit", {15'h0, phaseTransientAlarm}, 16'h0000);
            errPulse(thr + 16'h0001);
            check("alarm set", {15'h0, phaseTransientAlarm}, 16'h0001);
            check("build-out", {15'h0, phaseBuildOutPulse}, {15'h0, buildOutOnAlarmEnable});
            @(posedge clk);
            #1 check("build-out end", {15'h0, phaseBuildOutPulse}, 16'h0000);
            rd(STATUS_OFFSET, 8'h20, "status set");
            wr(STATUS_OFFSET, 8'h20);
            rd(STATUS_OFFSET, 8'h00, "status clear");
        end
        wr(TIMEOUT_OFFSET, 8'h02);
        lockAttempt = 1'b1;
        repeat (4 * SEC) @(posedge clk);
        #1 check("alarm early", {15'h0, phaseAlarm}, 16'h0000);
        waitAlarm(1'b1, SEC);
        check("alarm raised", {15'h0, phaseAlarm}, 16'h0001);
        lockAttempt = 1'b0;
        repeat (4 * SEC) @(posedge clk);
        #1 check("alarm held", {15'h0, phaseAlarm}, 16'h0001);
        waitAlarm(1'b0, 2 * SEC);
        check("alarm expired", {15'h0, phaseAlarm}, 16'h0000);
        close_out();
    end
endmodule : test_dpll_phase_monitor_regs
`default_nettype wire

/* verilog/dpll_phase_monitor_pkg.sv */
package dpll_phase_monitor_pkg;

    // ==========================================================
    // Register map and reset values
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] PHASE_LOW_OFFSET = 8'h77;
    localparam logic [7:0] PHASE_HIGH_OFFSET = 8'h78;
    localparam logic [7:0] TIMEOUT_OFFSET = 8'h79;
    localparam logic [7:0] PHASE_LOW_RESET = 8'h00;
    localparam logic [7:0] PHASE_HIGH_RESET = 8'h00;
    localparam logic [7:0] TIMEOUT_RESET = 8'h32;
    localparam int TRANSIENT_ALARM_BIT = 5;
    localparam int TIMEOUT_FIELD_MSB = 5;

    // ==========================================================
    // Transient threshold: (limit + offset) steps of 156.25 ns.
    // Phase error is measured in quarter nanoseconds.
    localparam int STEP_PS = 156250;
    localparam int QUARTER_NS_PS = 250;
    localparam logic [15:0] STEP_QNS = 16'(STEP_PS / QUARTER_NS_PS);
    localparam logic [15:0] LIMIT_OFFSET = 16'h0007;

    // ==========================================================
    // Timing of the phase-alarm timeout.
    localparam int CLK_PERIOD_NS = 8;
    localparam int SECOND_NS = 1000000000;
    localparam int CYCLES_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;

endpackage : dpll_phase_monitor_pkg

/* verilog/dpll_phase_monitor_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module dpll_phase_monitor_regs
    import dpll_phase_monitor_pkg::*;
#(
    parameter int PHASE_WIDTH = 16,
    parameter int AVG_SHIFT = 4,
    parameter int SECOND_CYCLES = dpll_phase_monitor_pkg::CYCLES_PER_SECOND
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Microprocessor port
    input wire logic [7:0] cpuAddr,
    input wire logic [7:0] cpuWrData,
    input wire logic cpuWrEn,
    input wire logic cpuRdEn,
    output logic [7:0] cpuRdData,
    // Phase detector samples
    input wire logic signed [PHASE_WIDTH-1:0] primaryPhase,
    input wire logic primaryPhaseValid,
    input wire logic signed [PHASE_WIDTH-1:0] secondaryPhase,
    input wire logic secondaryPhaseValid,
    input wire logic phaseSourceDpllSelect,
    // Phase transient monitor
    input wire logic monitorEnable,
    input wire logic buildOutOnAlarmEnable,
    input wire logic [3:0] transientLimit,
    input wire logic [15:0] phaseErrQns,
    input wire logic phaseErrValid,
    output logic phaseTransientAlarm,
    output logic phaseBuildOutPulse,
    // Locking timeout
    input wire logic lockAttempt,
    output logic phaseAlarm
);
    import dpll_phase_monitor_pkg::*;

    // Refuses a phase width other than the two byte registers and a degenerate second.
    if (PHASE_WIDTH != 16 || SECOND_CYCLES < 2)
    begin : paramCheck
        $error("dpll_phase_monitor_regs: unsupported parameters");
    end

    // ==========================================================
    // Phase readout path
    logic signed [PHASE_WIDTH-1:0] selSample;
    logic selValid;
    logic signed [PHASE_WIDTH-1:0] avgPhase;

    always_comb
    begin
        selSample = phaseSourceDpllSelect ? secondaryPhase : primaryPhase;
        selValid = phaseSourceDpllSelect ? secondaryPhaseValid : primaryPhaseValid;
    end

    // Signed arithmetic keeps the two's-complement encoding.
    phase_averager #(
        .WIDTH(PHASE_WIDTH),
        .SHIFT(AVG_SHIFT)
    ) u_avg (
        .clk(clk),
        .rstn(rstn),
        .sampleValid(selValid),
        .sample(selSample),
        .average(avgPhase)
    );

    // Reading the low byte freezes the high byte so both halves match.
    logic [7:0] highShadow_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            highShadow_q <= PHASE_HIGH_RESET;
        else if (cpuRdEn && cpuAddr == PHASE_LOW_OFFSET)
            highShadow_q <= avgPhase[15:8];
    end

    // ==========================================================
    // Transient monitor
    logic [15:0] thresholdQns;
    logic overLimit;
    logic clearAlarm;
    logic alarm_q;
    logic buildOut_q;

    always_comb
    begin
        thresholdQns = 16'(({12'h000, transientLimit} + LIMIT_OFFSET) * STEP_QNS);
        overLimit = monitorEnable && phaseErrValid && (phaseErrQns > thresholdQns);
        clearAlarm = cpuWrEn && cpuAddr == STATUS_OFFSET && cpuWrData[TRANSIENT_ALARM_BIT];
    end

    // The set wins over a software clear in the same cycle.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            alarm_q <= 1'b0;
        else if (overLimit)
            alarm_q <= 1'b1;
        else if (clearAlarm)
            alarm_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            buildOut_q <= 1'b0;
        else
            buildOut_q <= overLimit && !alarm_q && buildOutOnAlarmEnable;
    end

    assign phaseTransientAlarm = alarm_q;
    assign phaseBuildOutPulse = buildOut_q;

    // ==========================================================
    // Locking timeout
    logic [5:0] timeout_q;
    logic [31:0] tickCnt_q;
    logic secTick;
    logic [6:0] secCnt_q;
    logic expired;
    logic phaseAlarm_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            timeout_q <= TIMEOUT_RESET[5:0];
        else if (cpuWrEn && cpuAddr == TIMEOUT_OFFSET)
            timeout_q <= cpuWrData[TIMEOUT_FIELD_MSB:0];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            tickCnt_q <= '0;
        else if (tickCnt_q == 32'(SECOND_CYCLES - 1))
            tickCnt_q <= '0;
        else
            tickCnt_q <= tickCnt_q + 32'h0000_0001;
    end

    assign secTick = (tickCnt_q == 32'(SECOND_CYCLES - 1));
    assign expired = secTick && (secCnt_q >= {timeout_q, 1'b0});

    // Seconds count while locking or while the rejection stands.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            secCnt_q <= '0;
        else if (!(lockAttempt || phaseAlarm_q) || expired)
            secCnt_q <= '0;
        else if (secTick)
            secCnt_q <= secCnt_q + 7'h01;
    end

    // A rejection holds until a second timeout period has elapsed.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            phaseAlarm_q <= 1'b0;
        else if (expired && (lockAttempt || phaseAlarm_q))
            phaseAlarm_q <= !phaseAlarm_q;
    end

    assign phaseAlarm = phaseAlarm_q;

    // ==========================================================
    // Register read port
    logic [7:0] rdData_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdData_q <= 8'h00;
        else if (cpuRdEn)
        begin
            unique case (cpuAddr)
                STATUS_OFFSET: rdData_q <= 8'(alarm_q) << TRANSIENT_ALARM_BIT;
                PHASE_LOW_OFFSET: rdData_q <= avgPhase[7:0];
                PHASE_HIGH_OFFSET: rdData_q <= highShadow_q;
                TIMEOUT_OFFSET: rdData_q <= {2'b00, timeout_q};
                default: rdData_q <= 8'h00;
            endcase
        end
    end

    assign cpuRdData = rdData_q;

    // ==========================================================
    // Checks
    AST_ALARM_SET: assert property (@(posedge clk) disable iff (!rstn)
        (monitorEnable && phaseErrValid && phaseErrQns > 16'((32'(transientLimit) + 7) * 625)) |=> alarm_q)
        else $error("transient alarm not set");
    AST_ALARM_CAUSE: assert property (@(posedge clk) disable iff (!rstn)
        $rose(alarm_q) |-> $past(monitorEnable) && $past(phaseErrValid)
            && $past(phaseErrQns) > 16'(($past(transientLimit) + 16'd7) * 625))
        else $error("transient alarm without cause");
    AST_ALARM_DISABLED: assert property (@(posedge clk) disable iff (!rstn)
        (!monitorEnable && !alarm_q) |=> !alarm_q)
        else $error("alarm raised while monitor disabled");
    AST_BUILD_OUT: assert property (@(posedge clk) disable iff (!rstn)
        phaseBuildOutPulse |-> $rose(alarm_q) && $past(buildOutOnAlarmEnable) ##1 !phaseBuildOutPulse)
        else $error("bad build-out pulse");
    AST_READ_LOW: assert property (@(posedge clk) disable iff (!rstn)
        (cpuRdEn && cpuAddr == 8'h77) |=> cpuRdData == $past(avgPhase[7:0]))
        else $error("low phase byte mismatch");
    AST_READ_PAIR: assert property (@(posedge clk) disable iff (!rstn)
        (cpuRdEn && cpuAddr == 8'h77) ##1 (cpuRdEn && cpuAddr == 8'h78)
        |=> cpuRdData == $past(avgPhase[15:8], 2))
        else $error("high phase byte not paired with low");
    AST_TIMEOUT_RW: assert property (@(posedge clk) disable iff (!rstn)
        (cpuWrEn && cpuAddr == 8'h79) ##1 (cpuRdEn && cpuAddr == 8'h79 && !cpuWrEn)
        |=> cpuRdData == {2'b00, $past(cpuWrData[5:0], 2)})
        else $error("timeout register readback mismatch");
    AST_TIMEOUT_ALARM: assert property (@(posedge clk) disable iff (!rstn)
        $rose(phaseAlarm_q) |-> $past(lockAttempt) && $past(secCnt_q) >= {$past(timeout_q), 1'b0})
        else $error("phase alarm before timeout");

endmodule : dpll_phase_monitor_regs
`default_nettype wire

/* verilog/phase_averager.sv */
`timescale 1ns/1ps
`default_nettype none
module phase_averager #(
    parameter int WIDTH = 16,
    parameter int SHIFT = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Sample in
    input wire logic sampleValid,
    input wire logic signed [WIDTH-1:0] sample,
    // Average out
    output logic signed [WIDTH-1:0] average
);
    localparam int ACC_W = WIDTH + SHIFT;

    // Refuses widths and shifts that the accumulator cannot serve.
    if (SHIFT < 1 || SHIFT > 8 || WIDTH < 2)
    begin : paramCheck
        $error("phase_averager: unsupported WIDTH or SHIFT");
    end

    logic signed [ACC_W-1:0] acc_q;
    logic signed [ACC_W-1:0] acc_d;

    // First-order low-pass: the accumulator holds the mean scaled by 2**SHIFT.
    always_comb
    begin
        acc_d = acc_q + ACC_W'(sample) - (acc_q >>> SHIFT);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            acc_q <= '0;
        else if (sampleValid)
            acc_q <= acc_d;
    end

    assign average = acc_q[ACC_W-1:SHIFT];

endmodule : phase_averager
`default_nettype wire
